// >>> exc_map.svh
`ifndef EXC_MAP_SVH
`define EXC_MAP_SVH

// ****************************************************************
// execute-stage cycle and access counts at zero wait states
// ****************************************************************
`define EXC_CYC_SINGLE      5'h1
`define EXC_CYC_MUL_SB      5'h2
`define EXC_CYC_MUL_W       5'h4
`define EXC_CYC_MAC         5'h6
`define EXC_CYC_MAC_FRAC    5'h7
`define EXC_CYC_LD_B_AL     5'h2
`define EXC_CYC_LD_B_UN     5'h3
`define EXC_CYC_LD_W_AL     5'h2
`define EXC_CYC_LD_W_UN     5'h4
`define EXC_CYC_LD_D_AL     5'h3
`define EXC_CYC_LD_D_UN     5'h5
`define EXC_CYC_ST_B        5'h2
`define EXC_CYC_ST_W_AL     5'h2
`define EXC_CYC_ST_W_UN     5'h3
`define EXC_CYC_ST_D_AL     5'h3
`define EXC_CYC_ST_D_UN     5'h4
`define EXC_CYC_BIT_MOD     5'h4
`define EXC_CYC_BIT_TEST    5'h3
`define EXC_CYC_CTRL        5'h1
`define EXC_ACC_ONE         5'h1
`define EXC_ACC_TWO         5'h2
`define EXC_ACC_THREE       5'h3

// ****************************************************************
// pipeline refill after a flush, in cycles
// ****************************************************************
`define EXC_REFILL_CYC      2'h3

`endif

// >>> exc_pkg.sv
package exc_pkg;

	// ****************************************************************
	// instruction classes seen by the execute stage
	// ****************************************************************
	typedef enum logic [4:0] {
		CL_SINGLE,
		CL_MUL_SB,
		CL_MUL_W,
		CL_MAC,
		CL_MAC_FRAC,
		CL_LD_B,
		CL_LD_W,
		CL_LD_D,
		CL_ST_B,
		CL_ST_W,
		CL_ST_D,
		CL_SAVE,
		CL_SAVE_RA,
		CL_RESTORE,
		CL_RESTORE_RA,
		CL_RESTORE_RET,
		CL_BIT_MOD,
		CL_BIT_TEST,
		CL_BRANCH,
		CL_SERIAL
	} exc_class_e;

	typedef struct packed {
		exc_class_e  cls;
		logic        aligned;
		logic [3:0]  nreg;
	} exc_issue_s;

	typedef struct packed {
		logic        busy;
		logic        calc;
		logic [4:0]  cyc_left;
		logic [4:0]  acc_left;
		logic        flush_on_end;
		logic        writes_reg;
		logic [1:0]  refill;
		logic        ready;
		logic        last;
		logic        access;
		logic        done;
		logic        wr;
		logic        flush;
		logic        stall;
	} exc_state_s;

endpackage

// >>> exc_cost.sv
`timescale 1ns/100ps
`include "exc_map.svh"

module exc_cost (
	// instruction
	input  wire exc_pkg::exc_issue_s issue,
	// cost
	output logic [4:0]               cycles,
	output logic [4:0]               accesses
);

	logic [5:0] n6;
	logic [5:0] odd_acc;

	always_comb begin
		n6       = {2'h0, issue.nreg};
		odd_acc  = 6'(({n6[4:0], 1'h0} + n6 + 6'h1) >> 1);
		cycles   = `EXC_CYC_SINGLE;
		accesses = 5'h0;
		unique case (issue.cls)
			exc_pkg::CL_SINGLE, exc_pkg::CL_BRANCH, exc_pkg::CL_SERIAL: begin
				cycles = `EXC_CYC_SINGLE;
			end
			exc_pkg::CL_MUL_SB:   cycles = `EXC_CYC_MUL_SB;
			exc_pkg::CL_MUL_W:    cycles = `EXC_CYC_MUL_W;
			exc_pkg::CL_MAC:      cycles = `EXC_CYC_MAC;
			exc_pkg::CL_MAC_FRAC: cycles = `EXC_CYC_MAC_FRAC;
			exc_pkg::CL_LD_B: begin
				cycles   = issue.aligned ? `EXC_CYC_LD_B_AL : `EXC_CYC_LD_B_UN;
				accesses = `EXC_ACC_ONE;
			end
			exc_pkg::CL_LD_W: begin
				cycles   = issue.aligned ? `EXC_CYC_LD_W_AL : `EXC_CYC_LD_W_UN;
				accesses = issue.aligned ? `EXC_ACC_ONE : `EXC_ACC_TWO;
			end
			exc_pkg::CL_LD_D: begin
				cycles   = issue.aligned ? `EXC_CYC_LD_D_AL : `EXC_CYC_LD_D_UN;
				accesses = issue.aligned ? `EXC_ACC_TWO : `EXC_ACC_THREE;
			end
			exc_pkg::CL_ST_B: begin
				cycles   = `EXC_CYC_ST_B;
				accesses = `EXC_ACC_ONE;
			end
			exc_pkg::CL_ST_W: begin
				cycles   = issue.aligned ? `EXC_CYC_ST_W_AL : `EXC_CYC_ST_W_UN;
				accesses = issue.aligned ? `EXC_ACC_ONE : `EXC_ACC_TWO;
			end
			exc_pkg::CL_ST_D: begin
				cycles   = issue.aligned ? `EXC_CYC_ST_D_AL : `EXC_CYC_ST_D_UN;
				accesses = issue.aligned ? `EXC_ACC_TWO : `EXC_ACC_THREE;
			end
			exc_pkg::CL_SAVE: begin
				cycles   = 5'(n6 + (issue.aligned ? 6'h1 : 6'h2));
				accesses = 5'(n6 + (issue.aligned ? 6'h0 : 6'h1));
			end
			exc_pkg::CL_SAVE_RA: begin
				// pointer adjustment costs the extra cycle when unaligned
				cycles   = 5'(n6 + (issue.aligned ? 6'h1 : 6'h3));
				accesses = 5'(n6 + (issue.aligned ? 6'h0 : 6'h2));
			end
			exc_pkg::CL_RESTORE, exc_pkg::CL_RESTORE_RA, exc_pkg::CL_RESTORE_RET: begin
				if (issue.aligned) begin
					cycles   = 5'(n6 + 6'h2);
					accesses = 5'(n6);
				end else if (!n6[0]) begin
					cycles   = 5'({n6[4:0], 1'h0} + 6'h2);
					accesses = 5'(n6 + {1'h0, n6[5:1]});
				end else begin
					cycles   = 5'({n6[4:0], 1'h0} + 6'h3);
					accesses = odd_acc[4:0];
				end
				if (issue.cls == exc_pkg::CL_RESTORE_RET) begin
					cycles = 5'(cycles + 5'h1);
				end
			end
			exc_pkg::CL_BIT_MOD: begin
				cycles   = `EXC_CYC_BIT_MOD;
				accesses = `EXC_ACC_TWO;
			end
			exc_pkg::CL_BIT_TEST: begin
				cycles   = `EXC_CYC_BIT_TEST;
				accesses = `EXC_ACC_ONE;
			end
			default: begin
				cycles   = `EXC_CYC_SINGLE;
				accesses = 5'h0;
			end
		endcase
	end

endmodule

// >>> exc_timing.sv
`timescale 1ns/100ps
`include "exc_map.svh"

module exc_timing (
	// clock and reset
	input  wire logic                clk,
	input  wire logic                arst_n,
	// decode-stage hand-off
	input  wire logic                issue_valid,
	input  wire exc_pkg::exc_issue_s issue,
	output logic                     issue_ready,
	// core bus status
	input  wire logic                mem_rdy,
	input  wire logic                fetch_busy,
	// execute-stage status
	output logic                     ex_busy,
	output logic                     last_cycle_indication,
	output logic                     bus_access,
	output logic                     ex_stall,
	output logic                     ex_done,
	output logic                     reg_write,
	output logic                     pipe_flush
);

	// ****************************************************************
	// state
	// ****************************************************************
	exc_pkg::exc_state_s st_r;
	exc_pkg::exc_state_s st_nxt;
	logic [4:0]          cost_cyc;
	logic [4:0]          cost_acc;
	logic                take;
	logic                in_access;
	logic                hold;
	logic                ending;

	exc_cost u_cost (
		.issue    (issue),
		.cycles   (cost_cyc),
		.accesses (cost_acc)
	);

	assign take      = issue_valid && st_r.ready;
	assign in_access = st_r.busy && !st_r.calc && (st_r.acc_left != 5'h0);
	// an access is held while memory inserts wait states or a fetch is pending
	assign hold      = in_access && (!mem_rdy || fetch_busy);
	assign ending    = st_r.busy && !hold && (st_r.cyc_left == 5'h1);

	// ****************************************************************
	// next state
	// ****************************************************************
	always_comb begin
		st_nxt       = st_r;
		st_nxt.done  = 1'b0;
		st_nxt.wr    = 1'b0;
		st_nxt.flush = 1'b0;
		st_nxt.stall = hold;
		if (st_r.refill != 2'h0) begin
			st_nxt.refill = st_r.refill - 2'h1;
		end
		if (st_r.busy && !hold) begin
			st_nxt.calc     = 1'b0;
			st_nxt.cyc_left = st_r.cyc_left - 5'h1;
			if (in_access) begin
				st_nxt.acc_left = st_r.acc_left - 5'h1;
			end
		end
		if (ending) begin
			st_nxt.busy  = 1'b0;
			st_nxt.done  = 1'b1;
			st_nxt.wr    = st_r.writes_reg;
			st_nxt.flush = st_r.flush_on_end;
			if (st_r.flush_on_end) begin
				st_nxt.refill = `EXC_REFILL_CYC;
			end
		end
		if (take) begin
			st_nxt.busy         = 1'b1;
			st_nxt.calc         = 1'b1;
			st_nxt.cyc_left     = cost_cyc;
			st_nxt.acc_left     = cost_acc;
			st_nxt.flush_on_end = (issue.cls == exc_pkg::CL_RESTORE_RET) ||
			                      (issue.cls == exc_pkg::CL_BRANCH) ||
			                      (issue.cls == exc_pkg::CL_SERIAL);
			unique case (issue.cls)
				exc_pkg::CL_ST_B, exc_pkg::CL_ST_W, exc_pkg::CL_ST_D, exc_pkg::CL_SAVE,
				exc_pkg::CL_SAVE_RA, exc_pkg::CL_BIT_MOD, exc_pkg::CL_BRANCH,
				exc_pkg::CL_SERIAL: begin
					st_nxt.writes_reg = 1'b0;
				end
				default: begin
					st_nxt.writes_reg = 1'b1;
				end
			endcase
		end
		st_nxt.ready  = !st_nxt.busy && (st_nxt.refill == 2'h0);
		st_nxt.last   = st_nxt.busy && (st_nxt.cyc_left == 5'h1);
		st_nxt.access = st_nxt.busy && !st_nxt.calc && (st_nxt.acc_left != 5'h0);
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign issue_ready           = st_r.ready;
	assign ex_busy               = st_r.busy;
	assign last_cycle_indication = st_r.last;
	assign bus_access            = st_r.access;
	assign ex_stall              = st_r.stall;
	assign ex_done               = st_r.done;
	assign reg_write             = st_r.wr;
	assign pipe_flush            = st_r.flush;

	// ****************************************************************
	// checks
	// ****************************************************************
	logic bus_free;
	assign bus_free = mem_rdy && !fetch_busy;

	property p_single;
		@(posedge clk) disable iff (!arst_n)
		(take && issue.cls == exc_pkg::CL_SINGLE) |=> last_cycle_indication ##1 ex_done;
	endproperty
	a_single: assert property (p_single) else $error("single-cycle op not one cycle");

	property p_mul_word;
		@(posedge clk) disable iff (!arst_n)
		(take && issue.cls == exc_pkg::CL_MUL_W) |=> (!last_cycle_indication)[*3]
			##1 last_cycle_indication ##1 ex_done;
	endproperty
	a_mul_word: assert property (p_mul_word) else $error("word multiply not four cycles");

	property p_fetch_hold;
		@(posedge clk) disable iff (!arst_n)
		(bus_access && fetch_busy) |=> bus_access && !ex_done;
	endproperty
	a_fetch_hold: assert property (p_fetch_hold) else $error("access not held for fetch");

	property p_byte_load;
		@(posedge clk) disable iff (!arst_n)
		(take && issue.cls == exc_pkg::CL_LD_B && issue.aligned ##2 bus_free) |=> ex_done;
	endproperty
	a_byte_load: assert property (p_byte_load) else $error("aligned byte load not 2 cycles");

	property p_bit_mod;
		@(posedge clk) disable iff (!arst_n)
		(take && issue.cls == exc_pkg::CL_BIT_MOD ##2 bus_free[*2]) |=> ##1 ex_done;
	endproperty
	a_bit_mod: assert property (p_bit_mod) else $error("bit set/clear not 4 cycles");

	property p_write_done;
		@(posedge clk) disable iff (!arst_n)
		reg_write |-> ex_done && $past(ex_busy);
	endproperty
	a_write_done: assert property (p_write_done) else $error("write outside execute end");

	property p_last_before_done;
		@(posedge clk) disable iff (!arst_n)
		ex_done |-> $past(last_cycle_indication);
	endproperty
	a_last_before_done: assert property (p_last_before_done) else $error("done without last");

	property p_wait_state;
		@(posedge clk) disable iff (!arst_n)
		(bus_access && !mem_rdy) |=> bus_access && ex_busy;
	endproperty
	a_wait_state: assert property (p_wait_state) else $error("wait state not honoured");

	property p_refill;
		@(posedge clk) disable iff (!arst_n)
		pipe_flush |-> (!issue_ready)[*3] ##1 issue_ready;
	endproperty
	a_refill: assert property (p_refill) else $error("flush refill not three cycles");

	property p_mul_sbyte;
		@(posedge clk) disable iff (!arst_n)
		(take && issue.cls == exc_pkg::CL_MUL_SB) |=> !last_cycle_indication
			##1 last_cycle_indication ##1 ex_done;
	endproperty
	a_mul_sbyte: assert property (p_mul_sbyte) else $error("byte multiply not two cycles");

	property p_mac_frac;
		@(posedge clk) disable iff (!arst_n)
		(take && issue.cls == exc_pkg::CL_MAC_FRAC) |=> (!last_cycle_indication)[*6]
			##1 last_cycle_indication ##1 ex_done;
	endproperty
	a_mac_frac: assert property (p_mac_frac) else $error("fractional mac not seven cycles");

	property p_serial;
		@(posedge clk) disable iff (!arst_n)
		(take && issue.cls == exc_pkg::CL_SERIAL) |=> last_cycle_indication ##1 (ex_done && pipe_flush);
	endproperty
	a_serial: assert property (p_serial) else $error("serializing op did not flush");

	property p_flush_done;
		@(posedge clk) disable iff (!arst_n)
		pipe_flush |-> ex_done;
	endproperty
	a_flush_done: assert property (p_flush_done) else $error("flush away from instruction end");

	property p_done_pulse;
		@(posedge clk) disable iff (!arst_n)
		ex_done |=> !ex_done;
	endproperty
	a_done_pulse: assert property (p_done_pulse) else $error("done longer than one cycle");

	property p_stall_late;
		@(posedge clk) disable iff (!arst_n)
		ex_stall |-> bus_access && $past(bus_access);
	endproperty
	a_stall_late: assert property (p_stall_late) else $error("stall outside a held access");
endmodule

// >>> exc_mem_model.sv
`timescale 1ns/100ps

module exc_mem_model (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       arst_n,
	// bus from the core
	input  wire logic       bus_access,
	// wait-state setting
	input  wire logic [3:0] wait_cnt,
	input  wire logic       fetch_hold,
	// answers
	output logic            mem_rdy,
	output logic            fetch_busy
);

	logic [3:0] held_r;

	// ****************************************************************
	// hold each access for wait_cnt cycles
	// ****************************************************************
	always @(negedge clk or negedge arst_n) begin
		if (!arst_n) begin
			held_r     <= 4'h0;
			mem_rdy    <= 1'h1;
			fetch_busy <= 1'h0;
		end else if (bus_access && held_r < wait_cnt) begin
			held_r     <= held_r + 4'h1;
			mem_rdy    <= fetch_hold;
			fetch_busy <= fetch_hold;
		end else begin
			// ready toggles when no access is running
			held_r     <= 4'h0;
			mem_rdy    <= bus_access | ~mem_rdy;
			fetch_busy <= 1'h0;
		end
	end

endmodule

// >>> exc_timing_tb.sv
`timescale 1ns/100ps

module exc_timing_tb;

	logic                clk;
	logic                arst_n;
	logic                issue_valid;
	exc_pkg::exc_issue_s issue;
	logic                issue_ready;
	logic                mem_rdy;
	logic                fetch_busy;
	logic                ex_busy;
	logic                last_cycle_indication;
	logic                bus_access;
	logic                ex_stall;
	logic                ex_done;
	logic                reg_write;
	logic                pipe_flush;
	logic [3:0]          wait_cnt;
	logic                fetch_hold;
	int                  bad_count;
	int                  checks;
	int                  ticks;

	exc_timing dut_u (
		.clk                   (clk),
		.arst_n                (arst_n),
		.issue_valid           (issue_valid),
		.issue                 (issue),
		.issue_ready           (issue_ready),
		.mem_rdy               (mem_rdy),
		.fetch_busy            (fetch_busy),
		.ex_busy               (ex_busy),
		.last_cycle_indication (last_cycle_indication),
		.bus_access            (bus_access),
		.ex_stall              (ex_stall),
		.ex_done               (ex_done),
		.reg_write             (reg_write),
		.pipe_flush            (pipe_flush)
	);

	exc_mem_model mem_u (
		.clk        (clk),
		.arst_n     (arst_n),
		.bus_access (bus_access),
		.wait_cnt   (wait_cnt),
		.fetch_hold (fetch_hold),
		.mem_rdy    (mem_rdy),
		.fetch_busy (fetch_busy)
	);

	// ****************************************************************
	// clock, timeout and reporting
	// ****************************************************************
	initial begin
		clk = 1'h0;
		forever #25 clk = ~clk;
	end

	task automatic give_verdict();
		$display("checks=%0d bad_count=%0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	always @(posedge clk) begin
		ticks = ticks + 1;
		if (ticks == 5000) begin
			bad_count++;
			give_verdict();
		end
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// ****************************************************************
	// one instruction, judged on cycles, accesses and status
	// ****************************************************************
	task automatic run_op(input exc_pkg::exc_class_e c, input logic al, input logic [3:0] n,
		input int cy, input int ac);
		logic [31:0] busy_n = 32'h0;
		logic [31:0] acc_n = 32'h0;
		logic [31:0] stall_n = 32'h0;
		int   t = 0;
		int   held;
		logic was_last = 1'h0;
		logic first_last = 1'h0;
		logic ef;
		logic ew;
		ef = c inside {exc_pkg::CL_BRANCH, exc_pkg::CL_SERIAL, exc_pkg::CL_RESTORE_RET};
		ew = !(c inside {exc_pkg::CL_ST_B, exc_pkg::CL_ST_W, exc_pkg::CL_ST_D, exc_pkg::CL_SAVE,
			exc_pkg::CL_SAVE_RA, exc_pkg::CL_BIT_MOD, exc_pkg::CL_BRANCH, exc_pkg::CL_SERIAL});
		held = wait_cnt * ac;
		issue = '{cls: c, aligned: al, nreg: n};
		issue_valid = 1'h1;
		while (issue_ready !== 1'h1 && t < 50) begin
			@(negedge clk);
			t++;
		end
		@(negedge clk);
		issue_valid = 1'h0;
		t = 0;
		while (ex_done !== 1'h1 && t < 300) begin
			busy_n += ex_busy;
			acc_n += bus_access;
			stall_n += ex_stall;
			was_last = last_cycle_indication;
			if (t == 0) begin
				first_last = last_cycle_indication;
			end
			@(negedge clk);
			t++;
		end
		chk(busy_n, cy + held);
		chk(acc_n, ac + held);
		chk(stall_n, held);
		chk(was_last, 1'h1);
		chk(first_last, cy == 1);
		chk(reg_write, ew);
		chk(pipe_flush, ef);
		chk(issue_ready, !ef);
		if (ef) begin
			repeat (2) @(negedge clk);
			chk(issue_ready, 1'h0);
			@(negedge clk);
			chk(issue_ready, 1'h1);
		end
	endtask

	// ****************************************************************
	// scenarios
	// ****************************************************************
	task automatic t_arith();
		run_op(exc_pkg::CL_SINGLE, 1'h1, 4'h0, 1, 0);
		run_op(exc_pkg::CL_MUL_SB, 1'h1, 4'h0, 2, 0);
		run_op(exc_pkg::CL_MUL_W, 1'h1, 4'h0, 4, 0);
		run_op(exc_pkg::CL_MAC, 1'h1, 4'h0, 6, 0);
		run_op(exc_pkg::CL_MAC_FRAC, 1'h1, 4'h0, 7, 0);
		$display("arith test ended");
	endtask

	task automatic t_ldst();
		run_op(exc_pkg::CL_LD_B, 1'h1, 4'h0, 2, 1);
		run_op(exc_pkg::CL_LD_B, 1'h0, 4'h0, 3, 1);
		run_op(exc_pkg::CL_LD_W, 1'h1, 4'h0, 2, 1);
		run_op(exc_pkg::CL_LD_W, 1'h0, 4'h0, 4, 2);
		run_op(exc_pkg::CL_LD_D, 1'h1, 4'h0, 3, 2);
		run_op(exc_pkg::CL_LD_D, 1'h0, 4'h0, 5, 3);
		run_op(exc_pkg::CL_ST_B, 1'h1, 4'h0, 2, 1);
		run_op(exc_pkg::CL_ST_B, 1'h0, 4'h0, 2, 1);
		run_op(exc_pkg::CL_ST_W, 1'h1, 4'h0, 2, 1);
		run_op(exc_pkg::CL_ST_W, 1'h0, 4'h0, 3, 2);
		run_op(exc_pkg::CL_ST_D, 1'h1, 4'h0, 3, 2);
		run_op(exc_pkg::CL_ST_D, 1'h0, 4'h0, 4, 3);
		$display("load store test ended");
	endtask

	task automatic t_multi();
		run_op(exc_pkg::CL_SAVE, 1'h1, 4'h1, 2, 1);
		run_op(exc_pkg::CL_SAVE, 1'h0, 4'h8, 10, 9);
		run_op(exc_pkg::CL_SAVE_RA, 1'h1, 4'h8, 9, 8);
		run_op(exc_pkg::CL_SAVE_RA, 1'h0, 4'h1, 4, 3);
		run_op(exc_pkg::CL_RESTORE, 1'h1, 4'h8, 10, 8);
		run_op(exc_pkg::CL_RESTORE, 1'h0, 4'h8, 18, 12);
		run_op(exc_pkg::CL_RESTORE, 1'h0, 4'h1, 5, 2);
		run_op(exc_pkg::CL_RESTORE_RA, 1'h0, 4'hA, 22, 15);
		run_op(exc_pkg::CL_RESTORE_RA, 1'h0, 4'h9, 21, 14);
		run_op(exc_pkg::CL_RESTORE_RA, 1'h1, 4'hA, 12, 10);
		run_op(exc_pkg::CL_RESTORE_RET, 1'h0, 4'h3, 10, 5);
		run_op(exc_pkg::CL_RESTORE_RET, 1'h1, 4'h2, 5, 2);
		$display("multi register test ended");
	endtask

	task automatic t_bitctl();
		run_op(exc_pkg::CL_BIT_MOD, 1'h1, 4'h0, 4, 2);
		run_op(exc_pkg::CL_BIT_TEST, 1'h1, 4'h0, 3, 1);
		run_op(exc_pkg::CL_BRANCH, 1'h1, 4'h0, 1, 0);
		run_op(exc_pkg::CL_SERIAL, 1'h1, 4'h0, 1, 0);
		run_op(exc_pkg::CL_SINGLE, 1'h1, 4'h0, 1, 0);
		$display("bit and control test ended");
	endtask

	task automatic t_stall();
		wait_cnt = 4'h2;
		run_op(exc_pkg::CL_LD_D, 1'h0, 4'h0, 5, 3);
		run_op(exc_pkg::CL_ST_B, 1'h1, 4'h0, 2, 1);
		wait_cnt = 4'h1;
		run_op(exc_pkg::CL_SAVE_RA, 1'h0, 4'h8, 11, 10);
		fetch_hold = 1'h1;
		run_op(exc_pkg::CL_RESTORE_RA, 1'h0, 4'hA, 22, 15);
		wait_cnt = 4'h3;
		run_op(exc_pkg::CL_BIT_MOD, 1'h1, 4'h0, 4, 2);
		run_op(exc_pkg::CL_LD_W, 1'h0, 4'h0, 4, 2);
		wait_cnt = 4'h0;
		fetch_hold = 1'h0;
		$display("stall test ended");
	endtask

	initial begin
		arst_n = 1'h0;
		issue_valid = 1'h0;
		issue = '0;
		wait_cnt = 4'h0;
		fetch_hold = 1'h0;
		bad_count = 0;
		checks = 0;
		ticks = 0;
		repeat (5) @(negedge clk);
		arst_n = 1'h1;
		@(negedge clk);
		t_arith();
		t_ldst();
		t_multi();
		t_bitctl();
		t_stall();
		give_verdict();
	end

endmodule
